/* rtl/eair_pkg.sv */
// Constants for the egress action index resolver: field widths, encodings,
// key codes and reset values.
// Assumes one core clock; all users import the whole package.
//
// Summary of operation
// - Encapsulation index zero disables label push; 1 to 127 select an entry.
// - Alternate encapsulation index, same encoding, replaces primary under protection.
// - Pop field zero pops the header's 16-bit word count.
// - Pop field 1 pops nothing; 2 to 21 pop 2N bytes; 22-31 reserved.
// - Field byte count above header byte count falls back to header count.
// - A 10-bit service base selects the egress counter set.
// - Alternate 10-bit service base replaces primary when protection enables it.
// - Statistics index is base plus 3-bit per-class offset at 3*class.
// - Eight-bit map index gives address bits 10:3; key gives low part.
// - Maps 0 and 1 use resource A; maps 2 and 3 use resource B.
// - Key 0 adds QoS; key 1 adds DP*8 plus QoS.
// - Key 2 DSCP, key 3 64*DP plus DSCP, key 4 DP*8 plus precedence.
// - Key 5 PCP, key 6 DP*8 plus PCP, key 7 DEI*8 plus PCP.
// - Key 8 adds traffic class; key 9 adds DP*8 plus traffic class.
// - Key 10 popped PCP, key 11 DP*8 plus popped PCP, key 12 popped DEI*8 plus popped PCP.
// - Key 13 adds the class-of-service identifier.
// - Protection 0 ignores alternates; 1 uses them when active; 2 when inactive.

package eair_pkg;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int ENCAP_W     = 7;
  localparam int POP_FIELD_W = 5;
  localparam int HDR_POP_W   = 5;
  localparam int POP_BYTES_W = 7;
  localparam int SVC_W       = 10;
  localparam int OFFS_VEC_W  = 24;
  localparam int OFFS_W      = 3;
  localparam int MAP_IDX_W   = 8;
  localparam int MAP_ADDR_W  = 11;
  localparam int MAP_LOW_W   = 3;
  localparam int KEY_W       = 4;
  localparam int NUM_MAPS    = 4;
  localparam int MEP_W       = 8;
  localparam int DP_W        = 2;
  localparam int DSCP_W      = 6;

  // ----------------------------------------------------------------
  // Pop count field encodings
  // ----------------------------------------------------------------
  localparam logic [4:0] POP_USE_HDR = 5'h00;
  localparam logic [4:0] POP_NONE    = 5'h01;
  localparam logic [4:0] POP_MAX     = 5'h15;

  // ----------------------------------------------------------------
  // Protection selection encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PROT_OFF      = 2'h0;
  localparam logic [1:0] PROT_IF_ACT   = 2'h1;
  localparam logic [1:0] PROT_IF_INACT = 2'h2;

  // ----------------------------------------------------------------
  // Mapping key codes
  // ----------------------------------------------------------------
  localparam logic [3:0] KEY_QOS        = 4'h0;
  localparam logic [3:0] KEY_DP_QOS     = 4'h1;
  localparam logic [3:0] KEY_DSCP       = 4'h2;
  localparam logic [3:0] KEY_DP_DSCP    = 4'h3;
  localparam logic [3:0] KEY_DP_TOSPRE  = 4'h4;
  localparam logic [3:0] KEY_PCP        = 4'h5;
  localparam logic [3:0] KEY_DP_PCP     = 4'h6;
  localparam logic [3:0] KEY_DEI_PCP    = 4'h7;
  localparam logic [3:0] KEY_TC         = 4'h8;
  localparam logic [3:0] KEY_DP_TC      = 4'h9;
  localparam logic [3:0] KEY_POP_PCP    = 4'ha;
  localparam logic [3:0] KEY_DP_POP_PCP = 4'hb;
  localparam logic [3:0] KEY_PDEI_PPCP  = 4'hc;
  localparam logic [3:0] KEY_CLASS_OF_SERVICE_ID      = 4'hd;
  localparam logic [3:0] KEY_DP_CLASS_OF_SERVICE_ID   = 4'he;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [6:0]  RST_ENCAP = 7'h00;
  localparam logic [9:0]  RST_SVC   = 10'h000;
  localparam logic [10:0] RST_ADDR  = 11'h000;

endpackage

/* rtl/eair_map_index.sv */
// One mapping-table address former: base in the high bits plus a
// key-selected frame attribute.
// Assumes all inputs are stable for the cycle; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module eair_map_index
  import eair_pkg::*;
(
  input  wire logic [7:0]  map_base_address,
  input  wire logic [3:0]  key,
  input  wire logic [2:0]  qos,
  input  wire logic [1:0]  dp,
  input  wire logic [5:0]  dscp,
  input  wire logic [2:0]  pcp,
  input  wire logic        dei,
  input  wire logic [2:0]  tc,
  input  wire logic [2:0]  class_of_service_id,
  input  wire logic [2:0]  popped_pcp,
  input  wire logic        popped_dei,
  output logic      [10:0] addr,
  output logic             key_reserved
);

  logic [10:0] offs;
  logic [2:0]  tos_precedence_bits;

  // ----------------------------------------------------------------
  // Offset selection
  // ----------------------------------------------------------------
  // Offsets may spill past bits 2:0 on wide keys; the add carries into the base
  always_comb begin
    tos_precedence_bits = dscp[5:3];
    key_reserved        = 1'b0;
    offs                = 11'h000;
    case (key)
      KEY_QOS:        offs = {8'h00, qos};
      KEY_DP_QOS:     offs = {6'h00, dp, qos};
      KEY_DSCP:       offs = {5'h00, dscp};
      KEY_DP_DSCP:    offs = {3'h0, dp, dscp};
      KEY_DP_TOSPRE:  offs = {6'h00, dp, tos_precedence_bits};
      KEY_PCP:        offs = {8'h00, pcp};
      KEY_DP_PCP:     offs = {6'h00, dp, pcp};
      KEY_DEI_PCP:    offs = {7'h00, dei, pcp};
      KEY_TC:         offs = {8'h00, tc};
      KEY_DP_TC:      offs = {6'h00, dp, tc};
      // Popped tag keys; key 11 takes DP as its title says
      KEY_POP_PCP:    offs = {8'h00, popped_pcp};
      KEY_DP_POP_PCP: offs = {6'h00, dp, popped_pcp};
      KEY_PDEI_PPCP:  offs = {7'h00, popped_dei, popped_pcp};
      KEY_CLASS_OF_SERVICE_ID:      offs = {8'h00, class_of_service_id};
      KEY_DP_CLASS_OF_SERVICE_ID:   offs = {6'h00, dp, class_of_service_id};
      default:        key_reserved = 1'b1;
    endcase
  end

  assign addr = {map_base_address, 3'h0} + offs;

endmodule

`default_nettype wire

/* rtl/eair_resolver.sv */
// Egress action index resolver: turns one matched egress lookup action
// plus the frame's internal-header metadata into hardware indices.
// Assumes action and metadata arrive together with action_valid, one
// frame per cycle, all synchronous to clk; results appear one cycle later.
`timescale 1ns/1ps
`default_nettype none

module eair_resolver
  import eair_pkg::*;
#(
  parameter int ENCAP_WIDTH    = ENCAP_W,
  parameter int SVC_WIDTH      = SVC_W,
  parameter int MAP_IDX_WIDTH  = MAP_IDX_W
)
(
  input  wire logic                  clk,
  input  wire logic                  reset,

  // Action entry from the egress lookup stage
  input  wire logic                  action_valid,
  input  wire logic [6:0]            encapsulation_index,
  input  wire logic [6:0]            encapsulation_index_alt,
  input  wire logic [4:0]            pop_count_field,
  input  wire logic [9:0]            service_counter_base,
  input  wire logic [9:0]            service_counter_base_alt,
  input  wire logic [23:0]           per_class_counter_offsets,
  input  wire logic [7:0]            map_index_zero,
  input  wire logic [7:0]            map_index_one,
  input  wire logic [7:0]            map_index_two,
  input  wire logic [7:0]            map_index_three,
  input  wire logic [15:0]           map_keys,
  input  wire logic [1:0]            protection_select,
  input  wire logic [7:0]            maint_index,
  input  wire logic [7:0]            maint_index_alt,

  // Per-frame internal-header metadata
  input  wire logic [4:0]            header_word_pop_count,
  input  wire logic                  protection_active,
  input  wire logic [2:0]            qos,
  input  wire logic [1:0]            dp,
  input  wire logic [5:0]            dscp,
  input  wire logic [2:0]            pcp,
  input  wire logic                  dei,
  input  wire logic [2:0]            tc,
  input  wire logic [2:0]            class_of_service_id,
  input  wire logic [2:0]            popped_pcp,
  input  wire logic                  popped_dei,

  // Resolved indices, registered
  output logic                       result_valid,
  output logic                       encap_push_enable,
  output logic [6:0]                 encap_entry,
  output logic [6:0]                 pop_bytes,
  output logic                       pop_field_reserved,
  output logic [9:0]                 stat_index,
  output logic [7:0]                 maint_entry,
  output logic                       alternate_used,
  output logic [43:0]                map_addr,
  output logic [3:0]                 map_on_resource_b,
  output logic [3:0]                 map_key_reserved
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The logic is built at fixed field widths; other values are refused
  if (ENCAP_WIDTH != ENCAP_W || SVC_WIDTH != SVC_W ||
      MAP_IDX_WIDTH != MAP_IDX_W) begin : g_width_check
    $error("eair_resolver: unsupported width parameter");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             valid;
    logic             push_en;
    logic [6:0]       encap;
    logic [6:0]       pop_bytes;
    logic             pop_rsvd;
    logic [9:0]       stat;
    logic [7:0]       maint;
    logic             alt;
    logic [3:0][10:0] addr;
    logic [3:0]       res_b;
    logic [3:0]       key_rsvd;
  } eair_state_type;

  eair_state_type state_q;
  eair_state_type state_d;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Alternate selection is needed for three index kinds, so decode once here
  function automatic logic use_alternate(input logic [1:0] sel, input logic active);
    logic r;
    r = 1'b0;
    case (sel)
      PROT_IF_ACT:   r = active;
      PROT_IF_INACT: r = ~active;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction

  // Byte count for a 16-bit word count
  function automatic logic [6:0] words_to_bytes(input logic [4:0] words);
    return {1'b0, words, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // Combinational wires
  // ----------------------------------------------------------------
  logic             alt_sel;
  logic [6:0]       chosen_encap;
  logic [9:0]       chosen_base;
  logic [2:0]       class_offset;
  logic [6:0]       hdr_bytes;
  logic [6:0]       field_bytes;
  logic [6:0]       pop_result;
  logic             pop_rsvd;
  logic [3:0][7:0]  map_bases;
  logic [3:0][10:0] map_addr_c;
  logic [3:0]       map_rsvd_c;

  assign alt_sel = use_alternate(protection_select, protection_active);

  assign chosen_encap = alt_sel ? encapsulation_index_alt : encapsulation_index;

  assign chosen_base = alt_sel ? service_counter_base_alt : service_counter_base;

  assign class_offset = per_class_counter_offsets[3 * class_of_service_id +: OFFS_W];

  // ----------------------------------------------------------------
  // Pop byte count
  // ----------------------------------------------------------------
  assign hdr_bytes   = words_to_bytes(header_word_pop_count);
  assign field_bytes = words_to_bytes(pop_count_field);

  // Reserved field values fall back to the header count, the safe choice
  always_comb begin
    pop_rsvd   = 1'b0;
    pop_result = hdr_bytes;
    if (pop_count_field == POP_USE_HDR) begin
      pop_result = hdr_bytes;
    end else if (pop_count_field == POP_NONE) begin
      pop_result = 7'h00;
    end else if (pop_count_field > POP_MAX) begin
      pop_rsvd   = 1'b1;
      pop_result = hdr_bytes;
    end else if (field_bytes > hdr_bytes) begin
      pop_result = hdr_bytes;
    end else begin
      pop_result = field_bytes;
    end
  end

  // ----------------------------------------------------------------
  // Mapping address formers
  // ----------------------------------------------------------------
  assign map_bases[0] = map_index_zero;
  assign map_bases[1] = map_index_one;
  assign map_bases[2] = map_index_two;
  assign map_bases[3] = map_index_three;

  // One former per map; each reads its own 4-bit key slice
  for (genvar m = 0; m < NUM_MAPS; m++) begin : g_map
    eair_map_index u_map (
      .map_base_address    (map_bases[m]),
      .key                 (map_keys[m*KEY_W +: KEY_W]),
      .qos                 (qos),
      .dp                  (dp),
      .dscp                (dscp),
      .pcp                 (pcp),
      .dei                 (dei),
      .tc                  (tc),
      .class_of_service_id (class_of_service_id),
      .popped_pcp          (popped_pcp),
      .popped_dei          (popped_dei),
      .addr                (map_addr_c[m]),
      .key_reserved        (map_rsvd_c[m])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Valid follows action_valid each cycle; other results move only on a valid action, so they hold between frames
  always_comb begin
    state_d       = state_q;
    state_d.valid = action_valid;
    if (action_valid) begin
      state_d.alt      = alt_sel;
      state_d.encap    = chosen_encap;
      state_d.push_en  = (chosen_encap != RST_ENCAP);
      state_d.pop_bytes = pop_result;
      state_d.pop_rsvd = pop_rsvd;
      state_d.stat     = chosen_base + {7'h00, class_offset};
      state_d.maint    = alt_sel ? maint_index_alt : maint_index;
      state_d.addr     = map_addr_c;
      state_d.key_rsvd = map_rsvd_c;
      state_d.res_b    = 4'hc;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q          <= '0;
      state_q.encap    <= RST_ENCAP;
      state_q.stat     <= RST_SVC;
      state_q.addr     <= {NUM_MAPS{RST_ADDR}};
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign result_valid       = state_q.valid;
  assign encap_push_enable  = state_q.push_en;
  assign encap_entry        = state_q.encap;
  assign pop_bytes          = state_q.pop_bytes;
  assign pop_field_reserved = state_q.pop_rsvd;
  assign stat_index         = state_q.stat;
  assign maint_entry        = state_q.maint;
  assign alternate_used     = state_q.alt;
  assign map_addr           = state_q.addr;   // Map m at bits 11m+10:11m
  assign map_on_resource_b  = state_q.res_b;
  assign map_key_reserved   = state_q.key_rsvd;

endmodule

`default_nettype wire

/* bench/eair_resolver_chk.sv */
// Concurrent checks on the resolver's ports: latency, selection, pop and map rules.
// Assumes one clock domain and the async active-high reset of the resolver.
`timescale 1ns/1ps
`default_nettype none

module eair_resolver_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        action_valid,
  input wire logic [6:0]  encapsulation_index,
  input wire logic [6:0]  encapsulation_index_alt,
  input wire logic [4:0]  pop_count_field,
  input wire logic [9:0]  service_counter_base,
  input wire logic [9:0]  service_counter_base_alt,
  input wire logic [23:0] per_class_counter_offsets,
  input wire logic [7:0]  map_index_zero,
  input wire logic [15:0] map_keys,
  input wire logic [1:0]  protection_select,
  input wire logic [4:0]  header_word_pop_count,
  input wire logic        protection_active,
  input wire logic [2:0]  class_of_service_id,
  input wire logic        result_valid,
  input wire logic        encap_push_enable,
  input wire logic [6:0]  encap_entry,
  input wire logic [6:0]  pop_bytes,
  input wire logic        pop_field_reserved,
  input wire logic [9:0]  stat_index,
  input wire logic        alternate_used,
  input wire logic [43:0] map_addr,
  input wire logic [3:0]  map_on_resource_b,
  input wire logic [3:0]  map_key_reserved
);
  // ----------------------------------------
  // Expected values of the cycle's inputs
  // ----------------------------------------
  logic       alt_c;
  logic [6:0] pop_c;
  logic [9:0] stat_c;

  // Reference model kept flat so a slip in the design's mux tree shows up here
  always_comb begin
    alt_c  = (protection_select == 2'h1 && protection_active) || (protection_select == 2'h2 && !protection_active);
    stat_c = (alt_c ? service_counter_base_alt : service_counter_base)
             + 10'(per_class_counter_offsets[3*class_of_service_id +: 3]);
    pop_c  = {1'b0, header_word_pop_count, 1'b0};
    if (pop_count_field == 5'h01)
      pop_c = 7'h00;
    else if (pop_count_field > 5'h01 && pop_count_field < 5'h16 && 7'({pop_count_field, 1'b0}) < pop_c)
      pop_c = 7'({pop_count_field, 1'b0});
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_take;
    action_valid;
  endsequence

  sequence s_key_top;
    action_valid && map_keys[3:0] == 4'hf;
  endsequence

  encap_push_a: assert property (s_take |=> result_valid && encap_push_enable == (encap_entry != 7'h00))
    else $error("push enable does not follow chosen entry");
  encap_select_a: assert property (s_take |=> encap_entry == $past(alt_c ? encapsulation_index_alt : encapsulation_index))
    else $error("wrong encapsulation entry chosen");
  alt_choice_a: assert property (s_take |=> alternate_used == $past(alt_c))
    else $error("alternate selection wrong");
  stat_index_a: assert property (s_take |=> stat_index == $past(stat_c))
    else $error("statistics index wrong");
  pop_bytes_a: assert property (s_take |=> pop_bytes == $past(pop_c))
    else $error("pop byte count wrong");
  pop_reserved_a: assert property (s_take |=> pop_field_reserved == ($past(pop_count_field) > 5'h15))
    else $error("reserved pop flag wrong");
  map_resource_a: assert property (s_take |=> map_on_resource_b == 4'hc)
    else $error("map resource split wrong");
  key_reserved_a: assert property (s_key_top |=> map_key_reserved[0] && map_addr[10:0] == {$past(map_index_zero), 3'h0})
    else $error("reserved key address wrong");
  idle_hold_a: assert property (!action_valid |-> ##1 (!result_valid && $stable(stat_index) && $stable(map_addr)))
    else $error("outputs moved without an action");
endmodule

bind eair_resolver eair_resolver_chk u_chk (.*);

`default_nettype wire

/* bench/eair_resolver_tb_top.sv */
// Self-checking bench for the resolver: drives actions at the falling edge.
// Assumes the resolver's one-cycle registered answer and its default widths.
`timescale 1ns/1ps
`default_nettype none

module eair_resolver_tb_top
  import eair_pkg::*;
;
  logic        clk, reset, action_valid, protection_active, dei, popped_dei;
  logic        result_valid, encap_push_enable, pop_field_reserved, alternate_used;
  logic [1:0]  protection_select, dp;
  logic [2:0]  qos, pcp, tc, class_of_service_id, popped_pcp;
  logic [3:0]  map_on_resource_b, map_key_reserved;
  logic [4:0]  pop_count_field, header_word_pop_count;
  logic [5:0]  dscp;
  logic [6:0]  encapsulation_index, encapsulation_index_alt, encap_entry, pop_bytes;
  logic [7:0]  map_index_zero, map_index_one, map_index_two, map_index_three;
  logic [7:0]  maint_index, maint_index_alt, maint_entry;
  logic [9:0]  service_counter_base, service_counter_base_alt, stat_index;
  logic [15:0] map_keys;
  logic [23:0] per_class_counter_offsets;
  logic [43:0] map_addr;
  int          num_errors, compares;
  logic        alt;
  logic [6:0]  h2, pexp;

  eair_resolver DUT (.*);

  // Free-running core clock
  always #5 clk = ~clk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [43:0] got, input logic [43:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One isolated action; leaves us at the falling edge where results stand
  task fire();
    @(negedge clk);
    action_valid = 1'b1;
    @(negedge clk);
    action_valid = 1'b0;
    check(result_valid, 44'h1, "valid");
  endtask

  task give_verdict();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Expected map address, worked out independently of the design
  function automatic logic [10:0] map_exp(input logic [7:0] b, input logic [3:0] k);
    logic [10:0] o;
    case (k)
      4'h0: o = 11'(qos);
      4'h1: o = 11'({dp, qos});
      4'h2: o = 11'(dscp);
      4'h3: o = 11'({dp, dscp});
      4'h4: o = 11'({dp, dscp[5:3]});
      4'h5: o = 11'(pcp);
      4'h6: o = 11'({dp, pcp});
      4'h7: o = 11'({dei, pcp});
      4'h8: o = 11'(tc);
      4'h9: o = 11'({dp, tc});
      4'ha: o = 11'(popped_pcp);
      4'hb: o = 11'({dp, popped_pcp});
      4'hc: o = 11'({popped_dei, popped_pcp});
      4'hd: o = 11'(class_of_service_id);
      4'he: o = 11'({dp, class_of_service_id});
      default: o = 11'h000;
    endcase
    return {b, 3'h0} + o;
  endfunction

  // Hang guard: far beyond the hundred or so cycles the run needs
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0; reset = 1'b1; action_valid = 1'b0; protection_active = 1'b0;
    dei = 1'b1; popped_dei = 1'b1; protection_select = PROT_OFF; dp = 2'h3;
    qos = 3'h5; pcp = 3'h6; tc = 3'h2; class_of_service_id = 3'h7; popped_pcp = 3'h3;
    pop_count_field = POP_NONE; header_word_pop_count = 5'h0a; dscp = 6'h2d;
    encapsulation_index = 7'h05; encapsulation_index_alt = 7'h00;
    map_index_zero = 8'h00; map_index_one = 8'h81; map_index_two = 8'hfe; map_index_three = 8'hff;
    maint_index = 8'h3c; maint_index_alt = 8'hc3; service_counter_base = 10'h3fe;
    service_counter_base_alt = 10'h010; map_keys = 16'h0000; per_class_counter_offsets = 24'hfac688;
    num_errors = 0; compares = 0;
    repeat (3) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    check(result_valid, 44'h0, "valid in idle");
    // Protection modes crossed with the active flag; class id walks 0..7
    for (int ps = 0; ps < 4; ps++) begin
      for (int a = 0; a < 2; a++) begin
        protection_select = 2'(ps);
        protection_active = a[0];
        class_of_service_id = 3'(ps * 2 + a);
        fire();
        alt = (ps == 1 && a == 1) || (ps == 2 && a == 0);
        check(encap_entry, alt ? encapsulation_index_alt : encapsulation_index, "encap");
        check(encap_push_enable, {43'h0, !alt}, "push");
        check(alternate_used, {43'h0, alt}, "alt used");
        check(maint_entry, alt ? maint_index_alt : maint_index, "maint");
        check(stat_index, 10'((alt ? service_counter_base_alt : service_counter_base)
              + 10'(per_class_counter_offsets[3*class_of_service_id +: 3])), "stat");
      end
    end
    // Every pop field value, even ones against a small and odd ones against a large header count
    for (int f = 0; f < 32; f++) begin
      pop_count_field = 5'(f);
      header_word_pop_count = f[0] ? 5'h1f : 5'h0a;
      fire();
      h2 = {1'b0, header_word_pop_count, 1'b0};
      pexp = (f == 0 || f > 21) ? h2 : (f == 1) ? 7'h00 : (7'(2 * f) > h2) ? h2 : 7'(2 * f);
      check(pop_bytes, pexp, "pop bytes");
      check(pop_field_reserved, {43'h0, f > 21}, "pop reserved");
    end
    // Back-to-back actions through all keys; results trail the inputs by one
    @(negedge clk);
    for (int k = 0; k < 17; k++) begin
      if (k > 0) begin
        check(result_valid, 44'h1, "valid b2b");
        check(map_addr, {map_exp(map_index_three, 4'(k - 1)), map_exp(map_index_two, 4'(k - 1)),
              map_exp(map_index_one, 4'(k - 1)), map_exp(map_index_zero, 4'(k - 1))}, "map addr");
        check(map_on_resource_b, 44'hc, "resource");
        check(map_key_reserved, (k == 16) ? 44'hf : 44'h0, "key reserved");
      end
      map_keys = {4{4'(k)}};
      action_valid = (k < 16);
      @(negedge clk);
    end
    check(result_valid, 44'h0, "valid drop");
    check(map_addr[10:0], {map_index_zero, 3'h0}, "map hold");
    give_verdict();
  end
endmodule

`default_nettype wire
